// ==== verilog/cmxo_defines.vh ====
// Register map, field positions and timing constants for the clock multiplier control block
`ifndef CMXO_DEFINES_VH
`define CMXO_DEFINES_VH

`define CMXO_ADDR_MULT_CTRL   8'h00
`define CMXO_ADDR_XOSC        8'h04
`define CMXO_ADDR_STATUS      8'h08
`define CMXO_ADDR_W           8

`define CMXO_BIT_EN           7
`define CMXO_BIT_INIT         6
`define CMXO_BIT_RDY          5
`define CMXO_DIV_HI           4
`define CMXO_DIV_LO           2
`define CMXO_SEL_HI           1
`define CMXO_SEL_LO           0
`define CMXO_MULT_CTRL_RESET  8'h00

`define CMXO_XMODE_HI         6
`define CMXO_XMODE_LO         4
`define CMXO_FREQ_HI          2
`define CMXO_FREQ_LO          0
`define CMXO_XOSC_MASK        8'h77
`define CMXO_XOSC_RESET       8'h00

`define CMXO_SEL_INT_X2       2'h0
`define CMXO_SEL_EXT_X2       2'h1
`define CMXO_SEL_INT_X4       2'h2
`define CMXO_SEL_EXT_X4       2'h3

`define CMXO_XM_OFF           3'h0
`define CMXO_XM_CMOS          3'h2
`define CMXO_XM_CMOS_D2       3'h3
`define CMXO_XM_RC            3'h4
`define CMXO_XM_CAP           3'h5
`define CMXO_XM_XTAL          3'h6
`define CMXO_XM_XTAL_D2       3'h7

`define CMXO_LOCK_NS          2000
`define CMXO_CLK_NS           4

`define CMXO_HTRANS_NONSEQ    2'h2

`endif

// ==== verilog/cmxo_ctrl.v ====
// Clock multiplier control register, lock sequencer and oscillator pin claim over AHB-Lite
//
// Summary of operation
// - Enable bit 7 turns the clock multiplier off when clear, on when set.
// - Initialize bit 6 reads zero when the multiplier is newly enabled.
// - Writing one to initialize after enabling starts multiplier initialization.
// - Ready bit 5 reads one only after the multiplier output has stabilized.
// - Scale codes 000, 001 and 010 give a factor of one.
// - Codes 011..111 scale by 2/3, 1/2, 2/5, 1/3, 2/7.
// - Select 00 internal oscillator doubled; 01 external oscillator doubled.
// - Select 10 gives four times the internal oscillator.
// - Select 11 gives four times the external oscillator.
// - Doubling selections ignore the scale field and apply no scaling.
// - Crystal or resonator mode claims port 0 bits 2 and 3.
// - Capacitor, RC or CMOS clock mode claims only port 0 bit 3.
// - External oscillator supports crystal, resonator, capacitor, RC and CMOS clock.
// - Slow input gives four-pulse bursts averaging four times input frequency.
//
// Added by the designer: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "cmxo_defines.vh"

module cmxo_ctrl #(
  parameter LOCK_CYCLES = (`CMXO_LOCK_NS + `CMXO_CLK_NS - 1) / `CMXO_CLK_NS
) (
  // AHB-Lite clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Multiplier analog control
  input  wire        mult_locked,
  output reg         mult_power_on,
  output reg         mult_init_pulse,
  output reg         mult_clk_ready,
  output reg  [1:0]  mult_src_sel,
  output reg  [1:0]  mult_base_x4,
  output reg  [2:0]  mult_ratio_num,
  output reg  [2:0]  mult_ratio_den,
  // External oscillator drive and pin claim
  output reg  [2:0]  ext_osc_mode,
  output reg  [2:0]  ext_osc_freq_control,
  output reg         ext_osc_two_pin,
  output reg         port0_bit2_claim,
  output reg         port0_bit3_claim
);

  localparam ST_OFF  = 2'h0;
  localparam ST_IDLE = 2'h1;
  localparam ST_LOCK = 2'h2;
  localparam ST_RDY  = 2'h3;

  reg  [7:0]  clock_multiplier_control;
  reg  [7:0]  ext_osc_control_reg;
  reg  [1:0]  state;
  reg  [31:0] lock_cnt;
  reg         wr_pend;
  reg  [7:0]  wr_addr;
  reg  [1:0]  next_state;
  reg  [31:0] next_lock_cnt;
  reg  [7:0]  next_mult_ctrl;
  reg  [2:0]  next_num;
  reg  [2:0]  next_den;

  wire        addr_phase   = hsel & hready & (htrans == `CMXO_HTRANS_NONSEQ);
  wire        wr_mult_ctrl = wr_pend & (wr_addr == `CMXO_ADDR_MULT_CTRL);
  wire [7:0]  wbyte        = hwdata[7:0];

  // Doubling selections bypass the scaler
  function is_x2;
    input [1:0] sel;
    begin
      is_x2 = (sel == `CMXO_SEL_INT_X2) | (sel == `CMXO_SEL_EXT_X2);
    end
  endfunction

  // Crystal or resonator drives both pins
  function is_xtal;
    input [2:0] mode;
    begin
      is_xtal = (mode == `CMXO_XM_XTAL) | (mode == `CMXO_XM_XTAL_D2);
    end
  endfunction

  function is_one_pin;
    input [2:0] mode;
    begin
      is_one_pin = (mode == `CMXO_XM_CMOS) | (mode == `CMXO_XM_CMOS_D2) |
                   (mode == `CMXO_XM_RC) | (mode == `CMXO_XM_CAP);
    end
  endfunction

  // Register write and sequencer
  always @* begin
    next_mult_ctrl = clock_multiplier_control;
    next_state     = state;
    next_lock_cnt  = lock_cnt;
    if (wr_mult_ctrl) begin
      next_mult_ctrl[`CMXO_BIT_EN] = wbyte[`CMXO_BIT_EN];
      next_mult_ctrl[`CMXO_DIV_HI:`CMXO_SEL_LO] = wbyte[`CMXO_DIV_HI:`CMXO_SEL_LO];
      // Init sticks only if enable was already set before this write
      next_mult_ctrl[`CMXO_BIT_INIT] = wbyte[`CMXO_BIT_EN] &
        (clock_multiplier_control[`CMXO_BIT_INIT] |
         (wbyte[`CMXO_BIT_INIT] & clock_multiplier_control[`CMXO_BIT_EN]));
    end
    case (state)
      ST_OFF: begin
        if (next_mult_ctrl[`CMXO_BIT_EN])
          next_state = ST_IDLE;
      end
      ST_IDLE: begin
        if (wr_mult_ctrl & wbyte[`CMXO_BIT_INIT] & clock_multiplier_control[`CMXO_BIT_EN]) begin
          next_state    = ST_LOCK;
          next_lock_cnt = 32'h0000_0000;
        end
      end
      ST_LOCK: begin
        next_lock_cnt = lock_cnt + 32'h0000_0001;
        if ((lock_cnt >= LOCK_CYCLES - 1) & mult_locked)
          next_state = ST_RDY;
      end
      ST_RDY: begin
        if (wr_mult_ctrl & wbyte[`CMXO_BIT_INIT] & ~clock_multiplier_control[`CMXO_BIT_INIT]) begin
          next_state    = ST_LOCK;
          next_lock_cnt = 32'h0000_0000;
        end
      end
      default: next_state = ST_OFF;
    endcase
    // Disable or clearing the register drops readiness
    if (~next_mult_ctrl[`CMXO_BIT_EN])
      next_state = ST_OFF;
    next_mult_ctrl[`CMXO_BIT_RDY] = (next_state == ST_RDY);
  end

  // Scale factor as num/den of the x4 base
  always @* begin
    case (clock_multiplier_control[`CMXO_DIV_HI:`CMXO_DIV_LO])
      3'h3:    begin next_num = 3'h2; next_den = 3'h3; end
      3'h4:    begin next_num = 3'h2; next_den = 3'h4; end
      3'h5:    begin next_num = 3'h2; next_den = 3'h5; end
      3'h6:    begin next_num = 3'h2; next_den = 3'h6; end
      3'h7:    begin next_num = 3'h2; next_den = 3'h7; end
      default: begin next_num = 3'h1; next_den = 3'h1; end
    endcase
    if (is_x2(clock_multiplier_control[`CMXO_SEL_HI:`CMXO_SEL_LO])) begin
      next_num = 3'h1;
      next_den = 3'h1;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clock_multiplier_control <= `CMXO_MULT_CTRL_RESET;
      ext_osc_control_reg      <= `CMXO_XOSC_RESET;
      state                    <= ST_OFF;
      lock_cnt                 <= 32'h0000_0000;
      wr_pend                  <= 1'b0;
      wr_addr                  <= 8'h00;
      hrdata                   <= 32'h0000_0000;
      hreadyout                <= 1'b1;
      hresp                    <= 1'b0;
    end else begin
      clock_multiplier_control <= next_mult_ctrl;
      state                    <= next_state;
      lock_cnt                 <= next_lock_cnt;
      wr_pend                  <= addr_phase & hwrite;
      wr_addr                  <= haddr[`CMXO_ADDR_W-1:0];
      hreadyout                <= 1'b1;
      hresp                    <= 1'b0;
      if (wr_pend & (wr_addr == `CMXO_ADDR_XOSC))
        ext_osc_control_reg <= wbyte & `CMXO_XOSC_MASK;
      // Read data registered at address phase; zero-wait answer
      if (addr_phase & ~hwrite) begin
        case (haddr[`CMXO_ADDR_W-1:0])
          `CMXO_ADDR_MULT_CTRL: hrdata <= {24'h000000, clock_multiplier_control};
          `CMXO_ADDR_XOSC:      hrdata <= {24'h000000, ext_osc_control_reg};
          `CMXO_ADDR_STATUS:    hrdata <= {28'h0000000, mult_locked, port0_bit3_claim, state};
          default:           hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Registered outputs to the multiplier and pads
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mult_power_on        <= 1'b0;
      mult_init_pulse      <= 1'b0;
      mult_clk_ready       <= 1'b0;
      mult_src_sel         <= 2'h0;
      mult_base_x4         <= 2'h0;
      mult_ratio_num       <= 3'h1;
      mult_ratio_den       <= 3'h1;
      ext_osc_mode         <= 3'h0;
      ext_osc_freq_control <= 3'h0;
      ext_osc_two_pin      <= 1'b0;
      port0_bit2_claim     <= 1'b0;
      port0_bit3_claim     <= 1'b0;
    end else begin
      mult_power_on   <= clock_multiplier_control[`CMXO_BIT_EN];
      mult_init_pulse <= (state != ST_LOCK) & (next_state == ST_LOCK);
      mult_clk_ready  <= clock_multiplier_control[`CMXO_BIT_RDY];
      // Bit0: 0 internal, 1 external; x4 selects bit1
      mult_src_sel    <= clock_multiplier_control[`CMXO_SEL_HI:`CMXO_SEL_LO];
      case (clock_multiplier_control[`CMXO_SEL_HI:`CMXO_SEL_LO])
        `CMXO_SEL_INT_X4: mult_base_x4 <= 2'h1;
        `CMXO_SEL_EXT_X4: mult_base_x4 <= 2'h2;
        default:          mult_base_x4 <= 2'h0;
      endcase
      // Burst-of-four output on slow inputs is inherent to the analog loop
      mult_ratio_num  <= next_num;
      mult_ratio_den  <= next_den;
      ext_osc_mode         <= ext_osc_control_reg[`CMXO_XMODE_HI:`CMXO_XMODE_LO];
      ext_osc_freq_control <= ext_osc_control_reg[`CMXO_FREQ_HI:`CMXO_FREQ_LO];
      ext_osc_two_pin  <= is_xtal(ext_osc_control_reg[`CMXO_XMODE_HI:`CMXO_XMODE_LO]);
      port0_bit2_claim <= is_xtal(ext_osc_control_reg[`CMXO_XMODE_HI:`CMXO_XMODE_LO]);
      port0_bit3_claim <= is_xtal(ext_osc_control_reg[`CMXO_XMODE_HI:`CMXO_XMODE_LO]) |
                          is_one_pin(ext_osc_control_reg[`CMXO_XMODE_HI:`CMXO_XMODE_LO]);
    end
  end

endmodule // cmxo_ctrl

// ==== verification/cmxo_ctrl_chk.sv ====
// Port checker for the clock multiplier control block
`timescale 1ns/1ps
module cmxo_chk #(parameter LOCK_CYCLES = 500) (
  // Clock and reset
  input wire       hclk,
  input wire       hresetn,
  // Bus response
  input wire       hreadyout,
  input wire       hresp,
  // Multiplier
  input wire       mult_locked,
  input wire       mult_power_on,
  input wire       mult_init_pulse,
  input wire       mult_clk_ready,
  input wire [1:0] mult_src_sel,
  input wire [1:0] mult_base_x4,
  input wire [2:0] mult_ratio_num,
  input wire [2:0] mult_ratio_den,
  // Oscillator pins
  input wire [2:0] ext_osc_mode,
  input wire       ext_osc_two_pin,
  input wire       port0_bit2_claim,
  input wire       port0_bit3_claim
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Cycles since the last init pulse, saturating
  logic [15:0] cnt;
  always @(posedge hclk or negedge hresetn)
    if (!hresetn) cnt <= 16'h0000;
    else if (mult_init_pulse) cnt <= 16'h0000;
    else if (cnt != 16'hFFFF) cnt <= cnt + 16'h0001;
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
  a_ready_needs_power: assert property (mult_clk_ready |-> $past(mult_power_on))
    else $error("ready while multiplier off");
  a_ready_needs_lock: assert property ($rose(mult_clk_ready) |-> $past(mult_locked) || $past(mult_locked, 2))
    else $error("ready without lock");
  a_lock_time_kept: assert property ($rose(mult_clk_ready) |-> cnt >= LOCK_CYCLES - 1)
    else $error("ready before lock time");
  a_init_pulse_single: assert property (mult_init_pulse |-> mult_power_on ##1 !mult_init_pulse)
    else $error("init pulse bad");
  a_doubling_unscaled: assert property (mult_base_x4 == 2'h0 |-> mult_ratio_num == 3'h1 && mult_ratio_den == 3'h1)
    else $error("doubling select scaled");
  a_ratio_legal: assert property ((mult_ratio_num == 3'h1 && mult_ratio_den == 3'h1) ||
    (mult_ratio_num == 3'h2 && mult_ratio_den >= 3'h3)) else $error("bad ratio");
  a_base_from_sel: assert property (mult_base_x4 == (mult_src_sel[1] ? (mult_src_sel[0] ? 2'h2 : 2'h1) : 2'h0))
    else $error("base does not follow select");
  a_two_pin_claim: assert property ((port0_bit2_claim && ext_osc_two_pin) == (ext_osc_mode[2:1] == 2'h3))
    else $error("two pin claim wrong");
  a_pin3_claim: assert property (port0_bit3_claim == (ext_osc_mode >= 3'h2))
    else $error("pin 3 claim wrong");
  c_ready: cover property ($rose(mult_clk_ready));
  c_pulse: cover property (mult_init_pulse);
  c_claim: cover property (port0_bit2_claim);
endmodule // cmxo_chk
bind cmxo_ctrl cmxo_chk #(.LOCK_CYCLES(LOCK_CYCLES)) i_chk (.hclk(hclk), .hresetn(hresetn),
  .hreadyout(hreadyout), .hresp(hresp), .mult_locked(mult_locked), .mult_power_on(mult_power_on),
  .mult_init_pulse(mult_init_pulse), .mult_clk_ready(mult_clk_ready), .mult_src_sel(mult_src_sel),
  .mult_base_x4(mult_base_x4), .mult_ratio_num(mult_ratio_num), .mult_ratio_den(mult_ratio_den),
  .ext_osc_mode(ext_osc_mode), .ext_osc_two_pin(ext_osc_two_pin),
  .port0_bit2_claim(port0_bit2_claim), .port0_bit3_claim(port0_bit3_claim));

// ==== verification/cmxo_ctrl_tb.sv ====
// Self-checking bench for the clock multiplier control block
`timescale 1ns/1ps
`include "cmxo_defines.vh"
module cmxo_ctrl_tb;
  localparam LOCK = 4;
  localparam SETTLE = 1300; // Over 5 us of 4 ns cycles before init
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, mult_locked = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0]  htrans = 0, src, base;
  logic [2:0]  num, den, xm, xf;
  logic        hreadyout, hresp, pwr, ipulse, crdy, two, c2, c3;
  int          n_fail = 0, n_checks = 0;
  always #2 hclk = ~hclk;
  cmxo_ctrl #(.LOCK_CYCLES(LOCK)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .mult_locked(mult_locked), .mult_power_on(pwr),
    .mult_init_pulse(ipulse), .mult_clk_ready(crdy), .mult_src_sel(src), .mult_base_x4(base),
    .mult_ratio_num(num), .mult_ratio_den(den), .ext_osc_mode(xm), .ext_osc_freq_control(xf),
    .ext_osc_two_pin(two), .port0_bit2_claim(c2), .port0_bit3_claim(c3));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One single transfer; read data taken at the data phase's closing edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1; htrans <= `CMXO_HTRANS_NONSEQ; hwrite <= wr; haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 0; htrans <= 2'h0; hwdata <= wr ? d : 32'h0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic t_reset;
    bus(0, `CMXO_ADDR_MULT_CTRL, 0); chk("ctrl_reset", `CMXO_MULT_CTRL_RESET, rd);
    chk("ready_reset", 0, crdy);
    chk("bus_resp", 32'h2, {hreadyout, hresp});
    bus(0, `CMXO_ADDR_XOSC, 0); chk("xosc_reset", `CMXO_XOSC_RESET, rd);
    bus(1, 8'h10, 32'hFF); bus(0, 8'h10, 0); chk("unmapped", 0, rd);
  endtask
  task automatic t_scale;
    for (int s = 0; s < 4; s++)
      for (int c = 0; c < 8; c++) begin
        bus(1, `CMXO_ADDR_MULT_CTRL, {c[2:0], s[1:0]});
        repeat (2) @(posedge hclk);
        chk("base", s == 2 ? 1 : s == 3 ? 2 : 0, base);
        chk("src", s, src);
        chk("num", (s < 2 || c < 3) ? 1 : 2, num);
        chk("den", (s < 2 || c < 3) ? 1 : c, den);
      end
  endtask
  task automatic t_lock;
    mult_locked <= 1;
    bus(1, 0, 32'h00);
    bus(1, `CMXO_ADDR_XOSC, 32'h27);
    bus(1, 0, 32'h0F);
    bus(1, 0, 32'h8F);
    repeat (SETTLE) @(posedge hclk);
    bus(0, 0, 0); chk("enable_only", 32'h8F, rd);
    chk("power", 1, pwr);
    mult_locked <= 0;
    bus(1, 0, 32'hCF);
    @(posedge hclk);
    chk("init_pulse", 1, ipulse);
    @(posedge hclk);
    chk("init_once", 0, ipulse);
    repeat (4 * LOCK) @(posedge hclk);
    bus(0, 0, 0); chk("rdy_unlocked", 0, rd[5]);
    mult_locked <= 1;
    for (int i = 0; i < 20 && rd[5] !== 1'b1; i++) bus(0, 0, 0);
    chk("rdy_locked", 32'hEF, rd);
    bus(0, `CMXO_ADDR_STATUS, 0); chk("status", 32'h0F, rd);
    repeat (2) @(posedge hclk);
    chk("clk_ready", 1, crdy);
    bus(1, 0, 32'h0F); bus(0, 0, 0); chk("rdy_drop", 32'h0F, rd);
    chk("clk_ready_off", 0, crdy);
    chk("power_off", 0, pwr);
    bus(1, 0, 32'h8F);
    repeat (SETTLE) @(posedge hclk);
    bus(1, 0, 32'hCF);
    bus(0, 0, 0); chk("rdy_early", 0, rd[5]);
    for (int i = 0; i < 20 && rd[5] !== 1'b1; i++) bus(0, 0, 0);
    chk("rdy_relock", 32'hEF, rd);
  endtask
  task automatic t_osc;
    for (int m = 0; m < 8; m++) begin
      bus(1, `CMXO_ADDR_XOSC, {m[2:0], 4'h5}); bus(0, `CMXO_ADDR_XOSC, 0);
      chk("xosc_rd", {m[2:0], 4'h5}, rd);
      repeat (2) @(posedge hclk);
      chk("mode", {m[2:0], 3'h5}, {xm, xf});
      chk("pin2", m >= 6, c2);
      chk("two_pin", m >= 6, two);
      chk("pin3", m >= 2, c3);
    end
    bus(1, `CMXO_ADDR_XOSC, 32'hFF); bus(0, `CMXO_ADDR_XOSC, 0); chk("xosc_mask", 32'h77, rd);
  endtask
  task automatic final_report;
    if (n_fail == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    t_reset; t_scale; t_lock; t_osc;
    // Second reset in mid-run must bring both registers and clock ready back to reset values
    hresetn <= 0; @(posedge hclk); hresetn <= 1; @(posedge hclk);
    t_reset;
    final_report;
  end
  initial begin
    #40000;
    n_fail++;
    final_report;
  end
endmodule // cmxo_ctrl_tb
